/* File: shared/ccg_map.vh */
// Register map, reset values and timing constants of the clock generator.
// Included by the design; definitions only.
`ifndef CCG_MAP_VH
`define CCG_MAP_VH
`define CCG_ADDR_SETTLE 16'hfffa
`define CCG_ADDR_CPUSEL 16'hfffb
`define CCG_RST_SETTLE 3'h4
`define CCG_RST_CPUSEL 3'h4
`define CCG_DIV_MAX 3'h4
`define CCG_SEL_LSB 0
`define CCG_SEL_MSB 2
`define CCG_SETTLE_EXP0 5'd12
`define CCG_SETTLE_EXP1 5'd14
`define CCG_SETTLE_EXP2 5'd15
`define CCG_SETTLE_EXP3 5'd16
`define CCG_SETTLE_EXP4 5'd17
`define CCG_INSTR_CYC 5'd2
`define CCG_SWITCH_INSTR 5'd16
`endif

/* File: design/ccg_clock_gen.v */
// Clock generator: processor clock divider, peripheral divider and oscillator settling wait.
// Assumes the CPU register port is synchronous to clock; clock stands for the system clock.
// How it works
// - Reset loads the processor clock select register with 04H, system clock over sixteen.
// - Codes 000 to 100 divide the processor clock by 1, 2, 4, 8 or 16; other codes are refused.
// - Bits 3 to 7 of the processor clock select register read as zero and ignore writes.
// - The processor clock select register takes whole-byte writes and single-bit writes.
// - The settling select register is written as a whole byte only; bit writes are ignored.
// - Reset loads the settling select register with 04H.
// - The processor clock is held off for the settling wait after reset or STOP release.
// - Settling codes 000 to 100 give 2^12, 2^14, 2^15, 2^16 or 2^17 system clocks.
// - With the reset code the wait after reset is 2^17 system clocks.
// - The oscillator is stopped while rst_n is low.
// - A divider derives the peripheral clocks from the system clock.
// - Peripheral clocks stop whenever the system clock is stopped.
// - STOP halts oscillation and HALT halts only the processor clock.
// - A new divide setting takes effect after 16 cycles of the old processor clock.
`timescale 1ns/100ps
`include "ccg_map.vh"

module ccg_clock_gen #(
    parameter PERI_W = 8
) (
    // Clock and reset
    input wire clock,
    input wire rst_n,
    // Register port
    input wire [15:0] reg_addr,
    input wire reg_wr,
    input wire reg_bit_wr,
    input wire [2:0] reg_bit_idx,
    input wire [7:0] reg_wdata,
    output reg [7:0] reg_rdata,
    // Standby requests
    input wire stop_req,
    input wire halt_req,
    input wire wake,
    // Clock enables out
    output reg osc_run,
    output reg cpu_clk_en,
    output reg [PERI_W-1:0] peri_clk_en,
    output reg settle_busy
);

    function [4:0] settle_exp;
        input [2:0] code;
        begin
            case (code)
                3'h0: settle_exp = `CCG_SETTLE_EXP0;
                3'h1: settle_exp = `CCG_SETTLE_EXP1;
                3'h2: settle_exp = `CCG_SETTLE_EXP2;
                3'h3: settle_exp = `CCG_SETTLE_EXP3;
                default: settle_exp = `CCG_SETTLE_EXP4;
            endcase
        end
    endfunction

    // Both select fields share one legal range, 000 to 100
    function code_ok;
        input [2:0] code;
        begin
            code_ok = (code <= `CCG_DIV_MAX);
        end
    endfunction

    localparam ST_SETTLE = 2'h0;
    localparam ST_RUN = 2'h1;
    localparam ST_HALT = 2'h2;
    localparam ST_STOP = 2'h3;

    reg [2:0] cpu_sel_r;
    reg [2:0] cpu_act_r;
    reg [2:0] settle_sel_r;
    reg [1:0] state_r;
    reg [17:0] settle_cnt_r;
    reg [3:0] div_cnt_r;
    reg [PERI_W-1:0] peri_cnt_r;
    reg [8:0] sw_cnt_r;
    reg sw_pend_r;

    reg [2:0] cpu_sel_nxt;
    reg [7:0] bit_val;
    wire running = (state_r == ST_RUN);
    wire [17:0] settle_end = 18'h1 << settle_exp(settle_sel_r);
    wire [4:0] div_mask = (5'h1 << cpu_act_r) - 5'h1;
    wire cpu_tick = running && ((div_cnt_r & div_mask[3:0]) == 4'h0);
    // Switch delay in system clocks: 16 old-clock cycles, 16 shifted left by the active code
    wire [8:0] sw_len = {4'h0, `CCG_SWITCH_INSTR} << cpu_act_r;

    // Byte and single-bit writes merge into one candidate value
    always @* begin
        bit_val = {5'h0, cpu_sel_r};
        if (reg_bit_wr) begin
            bit_val[reg_bit_idx] = reg_wdata[0];
        end
        cpu_sel_nxt = cpu_sel_r;
        if (reg_addr == `CCG_ADDR_CPUSEL) begin
            if (reg_wr && code_ok(reg_wdata[2:0])) begin
                cpu_sel_nxt = reg_wdata[2:0];
            end else if (reg_bit_wr && code_ok(bit_val[2:0])) begin
                cpu_sel_nxt = bit_val[2:0];
            end
        end
    end

    // Select registers
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cpu_sel_r <= `CCG_RST_CPUSEL;
            settle_sel_r <= `CCG_RST_SETTLE;
        end else begin
            cpu_sel_r <= cpu_sel_nxt;
            // Prohibited settling codes are dropped; bit writes never reach it
            if (reg_wr && reg_addr == `CCG_ADDR_SETTLE && code_ok(reg_wdata[2:0])) begin
                settle_sel_r <= reg_wdata[2:0];
            end
        end
    end

    // Readback is registered, so data follows the address by one clock
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
        end else begin
            case (reg_addr)
                `CCG_ADDR_CPUSEL: reg_rdata <= {5'h00, cpu_sel_r};
                `CCG_ADDR_SETTLE: reg_rdata <= {5'h00, settle_sel_r};
                default: reg_rdata <= 8'h00;
            endcase
        end
    end

    // Divide switch: a further change restarts the delay, so only the last setting lands
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cpu_act_r <= `CCG_RST_CPUSEL;
            sw_cnt_r <= 9'h0;
            sw_pend_r <= 1'b0;
        end else begin
            // Old divide keeps running until the switch delay expires
            if (cpu_sel_nxt != cpu_sel_r) begin
                sw_pend_r <= 1'b1;
                sw_cnt_r <= 9'h0;
            end else if (sw_pend_r && osc_run) begin
                if (sw_cnt_r >= sw_len - 9'h1) begin
                    cpu_act_r <= cpu_sel_r;
                    sw_pend_r <= 1'b0;
                end else begin
                    sw_cnt_r <= sw_cnt_r + 9'h1;
                end
            end
        end
    end

    // Standby and settling sequence
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= ST_SETTLE;
            settle_cnt_r <= 18'h0;
        end else begin
            case (state_r)
                ST_SETTLE: begin
                    if (settle_cnt_r >= settle_end - 18'h1) begin
                        state_r <= ST_RUN;
                        settle_cnt_r <= 18'h0;
                    end else begin
                        settle_cnt_r <= settle_cnt_r + 18'h1;
                    end
                end
                ST_RUN: begin
                    if (stop_req) begin
                        state_r <= ST_STOP;
                    end else if (halt_req) begin
                        state_r <= ST_HALT;
                    end
                end
                ST_HALT: begin
                    if (wake) begin
                        state_r <= ST_RUN;
                    end
                end
                ST_STOP: begin
                    if (wake) begin
                        state_r <= ST_SETTLE;
                    end
                end
                default: state_r <= ST_SETTLE;
            endcase
        end
    end

    // Dividers and clock enables; every output here is a flip-flop
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            div_cnt_r <= 4'h0;
            peri_cnt_r <= {PERI_W{1'b0}};
            osc_run <= 1'b0;
            cpu_clk_en <= 1'b0;
            peri_clk_en <= {PERI_W{1'b0}};
            settle_busy <= 1'b1;
        end else begin
            osc_run <= (state_r != ST_STOP);
            div_cnt_r <= div_cnt_r + 4'h1;
            if (state_r != ST_STOP) begin
                peri_cnt_r <= peri_cnt_r + {{(PERI_W-1){1'b0}}, 1'b1};
            end
            // Each bit k is high for 2^k of every 2^(k+1) system clocks; all stop with oscillation
            peri_clk_en <= (state_r == ST_STOP) ? {PERI_W{1'b0}} : ~peri_cnt_r;
            cpu_clk_en <= cpu_tick;
            settle_busy <= (state_r == ST_SETTLE);
        end
    end

endmodule // ccg_clock_gen

/* File: test/ccg_monitor.sv */
// Port checker for the clock generator.
// Bound to ccg_clock_gen from the bench top; one clock domain.
`timescale 1ns/100ps
module ccg_monitor #(
    parameter PERI_W = 8
) (
    // Clock and reset
    input wire clock,
    input wire rst_n,
    // Register port
    input wire [15:0] reg_addr,
    input wire reg_wr,
    input wire [7:0] reg_wdata,
    input wire [7:0] reg_rdata,
    // Clock enables
    input wire osc_run,
    input wire cpu_clk_en,
    input wire [PERI_W-1:0] peri_clk_en,
    input wire settle_busy
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    a_settle_holds_cpu: assert property (settle_busy |-> !cpu_clk_en) else $error("cpu clock in settle");
    a_stop_no_cpu: assert property (!osc_run |-> !cpu_clk_en) else $error("cpu clock while stopped");
    a_stop_no_peri: assert property (!osc_run |-> peri_clk_en == 0) else $error("peri clock while stopped");
    a_start_settles: assert property ($rose(osc_run) |-> settle_busy) else $error("no settle on start");
    a_upper_zero: assert property (reg_rdata[7:3] == 5'h00) else $error("upper bits set");
    a_unmapped_zero: assert property ($past(reg_addr) != 16'hfffa && $past(reg_addr) != 16'hfffb
        |-> reg_rdata == 8'h00) else $error("unmapped read not zero");
    a_peri_toggle: assert property (osc_run ##1 osc_run |-> peri_clk_en[0] != $past(peri_clk_en[0]))
        else $error("peri bit0 not halving");
    a_byte_write: assert property (reg_wr && reg_addr == 16'hfffb && reg_wdata[2:0] <= 3'h4
        ##1 reg_addr == 16'hfffb |=> reg_rdata[2:0] == $past(reg_wdata[2:0], 2)) else $error("write lost");
    c_settle_end: cover property (settle_busy ##1 !settle_busy);
    c_stopped: cover property (!osc_run);
    c_sel_write: cover property (reg_wr && reg_addr == 16'hfffb);
endmodule // ccg_monitor

/* File: test/ccg_clock_gen_tb.sv */
// Self-checking bench for ccg_clock_gen; inputs change at falling edges.
// Assumes the design's shared/ccg_map.vh is on the include path.
`timescale 1ns/100ps
module ccg_clock_gen_tb;
    reg clock = 1'b0;
    reg rst_n = 1'b0;
    reg [15:0] reg_addr = 16'h0000;
    reg reg_wr = 1'b0;
    reg reg_bit_wr = 1'b0;
    reg [2:0] reg_bit_idx = 3'h0;
    reg [7:0] reg_wdata = 8'h00;
    reg stop_req = 1'b0;
    reg halt_req = 1'b0;
    reg wake = 1'b0;
    wire [7:0] reg_rdata;
    wire osc_run, cpu_clk_en, settle_busy;
    wire [7:0] peri_clk_en;
    integer err_total = 0;
    integer comparisons = 0;
    integer n, k;
    always #50 clock = ~clock;
    ccg_clock_gen u_dut (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_bit_wr(reg_bit_wr), .reg_bit_idx(reg_bit_idx), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .stop_req(stop_req), .halt_req(halt_req), .wake(wake), .osc_run(osc_run),
        .cpu_clk_en(cpu_clk_en), .peri_clk_en(peri_clk_en), .settle_busy(settle_busy));
    task conclude;
        $display("errors %0d comparisons %0d", err_total, comparisons);
        if (err_total == 0 && comparisons > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task chk(input [31:0] got, input [31:0] exp);
        comparisons = comparisons + 1;
        if (got !== exp) begin
            err_total = err_total + 1;
            $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    task wr(input [15:0] a, input [7:0] d, input b, input [2:0] i, input [7:0] e);
        @(negedge clock);
        {reg_addr, reg_wdata, reg_wr, reg_bit_wr, reg_bit_idx} = {a, d, !b, b, i};
        @(negedge clock);
        {reg_wr, reg_bit_wr} = 2'b00;
        @(negedge clock);
        chk(reg_rdata, e);
    endtask
    // Pulses on the two request lines that change state
    task pulse(input [1:0] s);
        @(negedge clock);
        {halt_req, stop_req} = s;
        @(negedge clock);
        {halt_req, stop_req} = 2'b00;
    endtask
    // Tolerance covers the edge spent entering and leaving the wait
    task settle(input integer exp);
        // After a wake the wait only opens two clocks later
        n = 0;
        while (settle_busy !== 1'b1 && n < 8) begin @(negedge clock); n = n + 1; end
        n = 0;
        while (settle_busy !== 1'b0 && n < 140000) begin @(negedge clock); n = n + 1; end
        chk(n >= exp - 3 && n <= exp + 3, 1);
    endtask
    task gap(input integer exp);
        n = 0;
        while (cpu_clk_en !== 1'b1 && n < 2000) begin @(negedge clock); n = n + 1; end
        n = 0;
        do begin @(negedge clock); n = n + 1; end while (cpu_clk_en !== 1'b1 && n < 2000);
        chk(n, exp);
    endtask
    initial begin
        #20000000;
        err_total = err_total + 1;
        conclude;
    end
    initial begin
        repeat (12) @(negedge clock);
        chk(osc_run, 0);
        rst_n = 1'b1;
        wr(16'hfffb, 8'hff, 0, 0, 8'h04);
        wr(16'hfffa, 8'h07, 0, 0, 8'h04);
        wr(16'h0000, 8'h00, 0, 0, 8'h00);
        settle(131072 - 9);
        gap(16);
        for (k = 0; k < 5; k = k + 1) begin
            wr(16'hfffb, k, 0, 0, k);
            repeat (300) @(negedge clock);
            gap(1 << k);
        end
        wr(16'hfffb, 8'h0b, 0, 0, 8'h03);
        gap(16);
        wr(16'hfffb, 8'h00, 1, 0, 8'h02);
        repeat (300) @(negedge clock);
        gap(4);
        wr(16'hfffa, 8'h00, 0, 0, 8'h00);
        wr(16'hfffa, 8'h01, 1, 2, 8'h00);
        pulse(2'b01);
        repeat (3) @(negedge clock);
        chk({osc_run, peri_clk_en}, 0);
        pulse(2'b00);
        wake = 1'b1;
        @(negedge clock);
        wake = 1'b0;
        settle(4096);
        pulse(2'b10);
        repeat (40) @(negedge clock);
        chk({osc_run, cpu_clk_en, settle_busy, peri_clk_en == 0}, 4'b1000);
        wake = 1'b1;
        @(negedge clock);
        wake = 1'b0;
        gap(4);
        conclude;
    end
endmodule // ccg_clock_gen_tb
bind ccg_clock_gen ccg_monitor #(.PERI_W(PERI_W)) u_mon (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .osc_run(osc_run),
    .cpu_clk_en(cpu_clk_en), .peri_clk_en(peri_clk_en), .settle_busy(settle_busy));
